// ==== include/ccr_pkg.sv ====
package ccr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_UNIT_NS = 1000;
  localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FG_CAL_TIME_NS = 20000;
  localparam int FG_CAL_CYC = (FG_CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_W = 6;
  localparam int STL_W = 3;
  localparam int SETTLE_MAX_CYC = (1 << STL_W) * SETTLE_UNIT_CYC;
  localparam int SETTLE_CNT_W = $clog2(SETTLE_MAX_CYC + 1);
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRIM = 8'h59;
  localparam logic [7:0] IDX_PLL_RST = 8'h5C;
  localparam logic [7:0] IDX_TUNE_CTRL = 8'h5D;
  localparam logic [7:0] IDX_TUNE_STAT = 8'h5E;
  localparam logic [7:0] IDX_CAL_RUN = 8'h61;
  localparam logic [7:0] IDX_CAL_SEL = 8'h62;
  localparam logic [7:0] IDX_LINK = 8'h70;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h71;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h72;
  localparam int STL_LSB = 4;
  localparam int TUNE_EN_BIT = 0;
  localparam int DONE_BIT = 0;
  localparam int RUN_BIT = 0;
  localparam int FG_BIT = 0;
  localparam int BG_BIT = 1;
  localparam int OS_BIT = 2;
  localparam int BGOS_BIT = 3;
  localparam int LINK_BIT = 0;
  localparam int PLL_RST_BIT = 0;
  localparam logic [7:0] TUNE_CTRL_RST = 8'h40;
  localparam logic [7:0] CAL_RUN_RST = 8'h01;
  localparam logic [7:0] CAL_SEL_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam int IRQ_W = 2;
  localparam int IRQ_TUNE_DONE = 0;
  localparam int IRQ_FG_DONE = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  typedef struct packed {
    logic [STL_W-1:0] settle;
    logic enable;
  } ccr_tune_cfg_t;

  typedef struct packed {
    logic bgOffset;
    logic fgOffset;
    logic bg;
    logic fg;
  } ccr_cal_sel_t;

  typedef struct packed {
    logic clearValues;
    logic fgActive;
    logic fgDone;
    logic bgEnable;
    logic fgOffsetEnable;
    logic bgOffsetEnable;
    logic divReset;
  } ccr_cal_out_t;

  typedef enum logic [3:0] {
    TUNE_IDLE = 4'b0001,
    TUNE_SETTLE = 4'b0010,
    TUNE_STEP = 4'b0100,
    TUNE_DONE = 4'b1000
  } ccr_tune_state_t;

  typedef enum logic [3:0] {
    CAL_HOLD = 4'b0001,
    CAL_CLEAR = 4'b0010,
    FOREGROUND_TRIM_ON = 4'b0100,
    CAL_RUN = 4'b1000
  } ccr_cal_state_t;
endpackage

// ==== tb/ccr_calibration_control_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_calibration_control_regs_asserts #(
  parameter int FG_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic synthPllReset,
  input wire logic [ccr_pkg::TRIM_W-1:0] oscTrimCode,
  input wire logic vcoTuneDone,
  input wire ccr_pkg::ccr_cal_out_t calOut
);
  import ccr_pkg::*;
  // Length of the current foreground phase
  logic [15:0] fgCnt_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) fgCnt_ff <= '0;
    else if (ce) fgCnt_ff <= calOut.fgActive ? fgCnt_ff + 16'h0001 : '0;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_done_clr; synthPllReset [*2] |-> !vcoTuneDone; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done under pll reset");
  property p_trim_kept; synthPllReset && !psel |=> $stable(oscTrimCode); endproperty
  a_trim_kept: assert property (p_trim_kept) else $error("trim moved in reset");
  property p_done_rise; $rose(vcoTuneDone) |-> !$past(synthPllReset); endproperty
  a_done_rise: assert property (p_done_rise) else $error("done rose in reset");
  property p_hold;
    calOut.divReset |-> calOut.clearValues && !calOut.fgActive && !calOut.bgEnable;
  endproperty
  a_hold: assert property (p_hold) else $error("hold state outputs wrong");
  property p_fg_os; calOut.fgOffsetEnable |-> calOut.fgActive; endproperty
  a_fg_os: assert property (p_fg_os) else $error("offset cal outside fg");
  property p_bg_os; calOut.bgOffsetEnable |-> calOut.bgEnable; endproperty
  a_bg_os: assert property (p_bg_os) else $error("bg offset without bg");
  property p_fg_pulse; calOut.fgDone |=> !calOut.fgDone; endproperty
  a_fg_pulse: assert property (p_fg_pulse) else $error("fg done not a pulse");
  property p_fg_len;
    $fell(calOut.fgActive) && !calOut.divReset |-> fgCnt_ff == FG_CYC;
  endproperty
  a_fg_len: assert property (p_fg_len) else $error("fg phase length wrong");
  c_fg: cover property (calOut.fgDone);
  c_tune: cover property ($rose(vcoTuneDone));
  c_err: cover property (pslverr);
endmodule
bind ccr_calibration_control_regs ccr_calibration_control_regs_asserts #(.FG_CYC(FG_CYC)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .synthPllReset(synthPllReset), .oscTrimCode(oscTrimCode),
  .vcoTuneDone(vcoTuneDone), .calOut(calOut));
`default_nettype wire

// ==== tb/ccr_calibration_control_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module ccr_calibration_control_regs_bench;
  import ccr_pkg::*;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, vcoFastIn;
  logic synthPllReset, vcoTuneDone, serialLinkEnable, irq, err;
  logic ce;
  logic [3:0] strb;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic [TRIM_W-1:0] trim, tgt;
  ccr_cal_out_t calOut;
  int failCount, nTests, cyc0, cyc3, n;
  ccr_calibration_control_regs #(.SETTLE_UNIT(2), .FG_CYC(8)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vcoFastIn(vcoFastIn), .synthPllReset(synthPllReset),
    .oscTrimCode(trim), .vcoTuneDone(vcoTuneDone), .calOut(calOut),
    .serialLinkEnable(serialLinkEnable), .irq(irq));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Comparator: VCO too fast when trim is above the target
  always @(posedge clk_sys) vcoFastIn <= (trim > tgt);
  task give_verdict;
    $display("Checks %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task timed_out(input int c, input int lim);
    if (c >= lim) begin
      failCount++;
      give_verdict;
    end
  endtask
  task xfer(input logic [7:0] idx, input logic [1:0] lo, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    timed_out(k, 20);
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(idx, 2'b00, 1'b1, d);
  endtask
  task rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
    xfer(idx, 2'b00, 1'b0, 32'h0000_0000);
    `CHK(nm, e, rdat)
  endtask
  task tune(input logic [7:0] ctl, input logic [5:0] t, output int c);
    wr(IDX_PLL_RST, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    `CHK("doneLow", 1'b0, vcoTuneDone)
    `CHK("pllPin", 1'b1, synthPllReset)
    tgt <= t;
    wr(IDX_TUNE_CTRL, {24'h00_0000, ctl});
    wr(IDX_PLL_RST, 32'h0000_0000);
    c = 0;
    while (vcoTuneDone !== 1'b1 && c < 5000) begin
      @(posedge clk_sys);
      c++;
    end
    timed_out(c, 5000);
  endtask
  task wait_cal(input logic fgWanted);
    n = 0;
    while ((fgWanted ? calOut.fgDone : calOut.fgActive) !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    timed_out(n, 50);
  endtask
  initial begin
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    ce = 1;
    strb = 4'hF;
    tgt = '0;
    failCount = 0;
    nTests = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1;
    rd("tuneCtrl", IDX_TUNE_CTRL, 32'h0000_0040);
    rd("calRun", IDX_CAL_RUN, 32'h0000_0001);
    rd("calSel", IDX_CAL_SEL, 32'h0000_0001);
    rd("pllRst", IDX_PLL_RST, 32'h0000_0000);
    rd("tuneStat", IDX_TUNE_STAT, 32'h0000_0001);
    wr(IDX_TUNE_STAT, 32'h0000_0000);
    rd("statRo", IDX_TUNE_STAT, 32'h0000_0001);
    xfer(8'hFF, 2'b00, 1'b0, 32'h0000_0000);
    `CHK("errMap", 1'b1, err)
    xfer(IDX_TUNE_CTRL, 2'b01, 1'b0, 32'h0000_0000);
    `CHK("errAlign", 1'b1, err)
    rd("irqStat", IDX_IRQ_STAT, 32'h0000_0003);
    `CHK("irqMasked", 1'b0, irq)
    wr(IDX_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    `CHK("irqOn", 1'b1, irq)
    wr(IDX_IRQ_STAT, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    `CHK("irqOff", 1'b0, irq)
    rd("irqW1c", IDX_IRQ_STAT, 32'h0000_0001);
    tune(8'h01, 6'h2B, cyc0);
    `CHK("trim", 6'h2B, trim)
    rd("trimReg", IDX_TRIM, 32'h0000_002B);
    wr(IDX_PLL_RST, 32'h0000_0001);
    repeat (20) @(posedge clk_sys);
    rd("trimKept", IDX_TRIM, 32'h0000_002B);
    tune(8'h31, 6'h15, cyc3);
    `CHK("trim3", 6'h15, trim)
    // Start overhead cancels; six settles, each 3*2 cycles longer
    `CHK("settle", 36, cyc3 - cyc0)
    tune(8'h40, 6'h00, cyc0);
    `CHK("skip", 1'b1, cyc0 < 8)
    wr(IDX_TRIM, 32'h0000_000A);
    rd("trimSw", IDX_TRIM, 32'h0000_000A);
    wr(IDX_CAL_RUN, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    `CHK("divRst", 1'b1, calOut.divReset)
    `CHK("clrVal", 1'b1, calOut.clearValues)
    wr(IDX_CAL_SEL, 32'h0000_000F);
    rd("selNew", IDX_CAL_SEL, 32'h0000_000F);
    wr(IDX_CAL_RUN, 32'h0000_0001);
    wait_cal(1'b0);
    `CHK("fgOs", 1'b1, calOut.fgOffsetEnable)
    // Clock enable low must freeze the foreground phase past its length
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys);
    `CHK("ceHold", 1'b1, calOut.fgActive)
    ce <= 1'b1;
    wait_cal(1'b1);
    repeat (2) @(posedge clk_sys);
    `CHK("bgOn", 1'b1, calOut.bgEnable)
    `CHK("bgOs", 1'b1, calOut.bgOffsetEnable)
    `CHK("divRun", 1'b0, calOut.divReset)
    wr(IDX_CAL_RUN, 32'h0000_0000);
    wr(IDX_CAL_SEL, 32'h0000_000A);
    wr(IDX_CAL_RUN, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    `CHK("fgSkip", 1'b1, calOut.bgEnable)
    wr(IDX_CAL_RUN, 32'h0000_0000);
    wr(IDX_CAL_SEL, 32'h0000_000C);
    wr(IDX_CAL_RUN, 32'h0000_0001);
    repeat (12) @(posedge clk_sys);
    `CHK("bgOsAlone", 1'b0, calOut.bgOffsetEnable)
    `CHK("bgOff", 1'b0, calOut.bgEnable)
    // Low byte lane off: the write must be ignored
    strb <= 4'hE;
    wr(IDX_LINK, 32'h0000_0001);
    strb <= 4'hF;
    rd("strbOff", IDX_LINK, 32'h0000_0000);
    wr(IDX_LINK, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    `CHK("link", 1'b1, serialLinkEnable)
    rd("linkReg", IDX_LINK, 32'h0000_0001);
    give_verdict;
  end
endmodule
`default_nettype wire

// ==== verilog/ccr_cal_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_cal_seq #(
  parameter int FG_CYC = ccr_pkg::FG_CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  input wire ccr_pkg::ccr_cal_sel_t sel,
  output ccr_pkg::ccr_cal_out_t calOut
);
  import ccr_pkg::*;
  localparam int FG_CNT_W = $clog2(FG_CYC + 1);

  ccr_cal_state_t state_ff, nxt_state;
  ccr_cal_sel_t sel_ff, nxt_sel;
  ccr_cal_out_t out_ff, nxt_out;
  logic [FG_CNT_W-1:0] cnt_ff, nxt_cnt;

  assign calOut = out_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_cnt = cnt_ff;
    nxt_out = '0;
    case (state_ff)
      CAL_HOLD: begin
        nxt_out.clearValues = 1'b1;
        nxt_out.divReset = 1'b1;
        if (run) begin
          // Settings are taken once, so a rerun sees new ones
          nxt_sel = sel;
          nxt_state = CAL_CLEAR;
        end
      end
      CAL_CLEAR: begin
        nxt_out.clearValues = 1'b1;
        nxt_cnt = FG_CNT_W'(FG_CYC - 1);
        nxt_state = sel_ff.fg ? FOREGROUND_TRIM_ON : CAL_RUN;
        nxt_out.fgActive = sel_ff.fg;
        nxt_out.fgOffsetEnable = sel_ff.fg & sel_ff.fgOffset;
      end
      FOREGROUND_TRIM_ON: begin
        nxt_out.fgActive = 1'b1;
        nxt_out.fgOffsetEnable = sel_ff.fgOffset;
        if (cnt_ff == '0) begin
          nxt_out.fgActive = 1'b0;
          nxt_out.fgOffsetEnable = 1'b0;
          nxt_out.fgDone = 1'b1;
          nxt_state = CAL_RUN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      CAL_RUN: begin
        nxt_out.bgEnable = sel_ff.bg;
        nxt_out.bgOffsetEnable = sel_ff.bg & sel_ff.bgOffset;
      end
      default: begin
        nxt_state = CAL_HOLD;
      end
    endcase
    if (!run) begin
      nxt_state = CAL_HOLD;
      nxt_out = '0;
      nxt_out.clearValues = 1'b1;
      nxt_out.divReset = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= CAL_HOLD;
      sel_ff <= '0;
      cnt_ff <= '0;
      out_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/ccr_calibration_control_regs.sv ====
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ccr_calibration_control_regs #(
  parameter int SETTLE_UNIT = ccr_pkg::SETTLE_UNIT_CYC,
  parameter int FG_CYC = ccr_pkg::FG_CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [ccr_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ccr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vcoFastIn,
  output logic synthPllReset,
  output logic [ccr_pkg::TRIM_W-1:0] oscTrimCode,
  output logic vcoTuneDone,
  output ccr_pkg::ccr_cal_out_t calOut,
  output logic serialLinkEnable,
  output logic irq
);
  import ccr_pkg::*;

  // Register storage
  logic [REG_W-1:0] pllRst_ff, nxt_pllRst;
  logic [REG_W-1:0] tuneCtrl_ff, nxt_tuneCtrl;
  logic [REG_W-1:0] calRun_ff, nxt_calRun;
  logic [REG_W-1:0] calSel_ff, nxt_calSel;
  logic [REG_W-1:0] link_ff, nxt_link;
  logic [IRQ_W-1:0] irqStat_ff, nxt_irqStat;
  logic [IRQ_W-1:0] irqMask_ff, nxt_irqMask;
  logic irq_ff, nxt_irq;
  logic [DATA_W-1:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // Bus decode
  wire setupPh;
  wire commit;
  wire aligned;
  wire [7:0] regIdx;
  wire selTrim;
  wire selPllRst;
  wire selTuneCtrl;
  wire selTuneStat;
  wire selCalRun;
  wire selCalSel;
  wire selLink;
  wire selIrqStat;
  wire selIrqMask;
  wire mapped;
  wire wrEn;
  wire [REG_W-1:0] wrByte;
  wire [REG_W-1:0] rdByte;

  // Engine connections
  ccr_tune_cfg_t tuneCfg;
  ccr_cal_sel_t calSel;
  ccr_cal_out_t calSeqOut;
  wire [TRIM_W-1:0] trimCode;
  wire tuneDone;
  wire tuneDonePulse;
  wire trimWe;
  wire [IRQ_W-1:0] events;

  assign setupPh = psel & ~penable;
  // A write lands only at the edge that also samples pready high
  assign commit = psel & penable & pready_ff;
  assign aligned = (paddr[1:0] == 2'b00);
  assign regIdx = paddr[ADDR_W-1:2];
  assign selTrim = aligned & (regIdx == IDX_TRIM);
  assign selPllRst = aligned & (regIdx == IDX_PLL_RST);
  assign selTuneCtrl = aligned & (regIdx == IDX_TUNE_CTRL);
  assign selTuneStat = aligned & (regIdx == IDX_TUNE_STAT);
  assign selCalRun = aligned & (regIdx == IDX_CAL_RUN);
  assign selCalSel = aligned & (regIdx == IDX_CAL_SEL);
  assign selLink = aligned & (regIdx == IDX_LINK);
  assign selIrqStat = aligned & (regIdx == IDX_IRQ_STAT);
  assign selIrqMask = aligned & (regIdx == IDX_IRQ_MASK);
  assign mapped = selTrim | selPllRst | selTuneCtrl | selTuneStat | selCalRun
                | selCalSel | selLink | selIrqStat | selIrqMask;
  // Registers are one byte wide, so only the low lane matters
  assign wrEn = commit & pwrite & pstrb[0] & mapped;
  assign wrByte = pwdata[REG_W-1:0];

  assign rdByte = ({REG_W{selTrim}} & {{(REG_W-TRIM_W){1'b0}}, trimCode})
                | ({REG_W{selPllRst}} & pllRst_ff)
                | ({REG_W{selTuneCtrl}} & tuneCtrl_ff)
                | ({REG_W{selTuneStat}} & {{(REG_W-1){1'b0}}, tuneDone})
                | ({REG_W{selCalRun}} & calRun_ff)
                | ({REG_W{selCalSel}} & calSel_ff)
                | ({REG_W{selLink}} & link_ff)
                | ({REG_W{selIrqStat}} & {{(REG_W-IRQ_W){1'b0}}, irqStat_ff})
                | ({REG_W{selIrqMask}} & {{(REG_W-IRQ_W){1'b0}}, irqMask_ff});

  // Reserved bits are stored as written, except in the irq mask, irq status and trim; software keeps them at reset value
  assign nxt_pllRst = (wrEn & selPllRst) ? wrByte : pllRst_ff;
  assign nxt_tuneCtrl = (wrEn & selTuneCtrl) ? wrByte : tuneCtrl_ff;
  assign nxt_calRun = (wrEn & selCalRun) ? wrByte : calRun_ff;
  assign nxt_calSel = (wrEn & selCalSel) ? wrByte : calSel_ff;
  assign nxt_link = (wrEn & selLink) ? wrByte : link_ff;
  assign nxt_irqMask = (wrEn & selIrqMask) ? wrByte[IRQ_W-1:0] : irqMask_ff;
  assign trimWe = wrEn & selTrim;

  assign events[IRQ_TUNE_DONE] = tuneDonePulse;
  assign events[IRQ_FG_DONE] = calSeqOut.fgDone;
  // Hardware set wins over a same-cycle write-one clear
  assign nxt_irqStat = (irqStat_ff & ~({IRQ_W{wrEn & selIrqStat}} & wrByte[IRQ_W-1:0]))
                     | events;
  assign nxt_irq = |(nxt_irqStat & nxt_irqMask);

  assign nxt_pready = setupPh;
  assign nxt_prdata = setupPh ? {{(DATA_W-REG_W){1'b0}}, rdByte} : prdata_ff;
  assign nxt_pslverr = setupPh & ~mapped;

  // Tuning enable is sampled when a run starts after PLL reset release; settle is reread at every settle reload
  assign tuneCfg.settle = tuneCtrl_ff[STL_LSB +: STL_W];
  assign tuneCfg.enable = tuneCtrl_ff[TUNE_EN_BIT];
  assign calSel.fg = calSel_ff[FG_BIT];
  assign calSel.bg = calSel_ff[BG_BIT];
  assign calSel.fgOffset = calSel_ff[OS_BIT];
  assign calSel.bgOffset = calSel_ff[BGOS_BIT];

  ccr_vco_tuner #(
    .SETTLE_UNIT(SETTLE_UNIT)
  ) u_tuner (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .pllReset(pllRst_ff[PLL_RST_BIT]),
    .cfg(tuneCfg),
    .vcoFastIn(vcoFastIn),
    .swTrimWe(trimWe),
    .swTrim(wrByte[TRIM_W-1:0]),
    .trim(trimCode),
    .done(tuneDone),
    .donePulse(tuneDonePulse)
  );

  ccr_cal_seq #(
    .FG_CYC(FG_CYC)
  ) u_cal (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .run(calRun_ff[RUN_BIT]),
    .sel(calSel),
    .calOut(calSeqOut)
  );

  // Engine outputs are flip-flops inside the engines
  assign oscTrimCode = trimCode;
  assign vcoTuneDone = tuneDone;
  assign calOut = calSeqOut;
  assign synthPllReset = pllRst_ff[PLL_RST_BIT];
  assign serialLinkEnable = link_ff[LINK_BIT];
  assign irq = irq_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pllRst_ff <= ZERO_RST;
      tuneCtrl_ff <= TUNE_CTRL_RST;
      calRun_ff <= CAL_RUN_RST;
      calSel_ff <= CAL_SEL_RST;
      link_ff <= ZERO_RST;
    end else if (ce) begin
      pllRst_ff <= nxt_pllRst;
      tuneCtrl_ff <= nxt_tuneCtrl;
      calRun_ff <= nxt_calRun;
      calSel_ff <= nxt_calSel;
      link_ff <= nxt_link;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqStat_ff <= IRQ_RST;
      irqMask_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else if (ce) begin
      irqStat_ff <= nxt_irqStat;
      irqMask_ff <= nxt_irqMask;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/ccr_vco_tuner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccr_vco_tuner #(
  parameter int SETTLE_UNIT = ccr_pkg::SETTLE_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pllReset,
  input wire ccr_pkg::ccr_tune_cfg_t cfg,
  input wire logic vcoFastIn,
  input wire logic swTrimWe,
  input wire logic [ccr_pkg::TRIM_W-1:0] swTrim,
  output logic [ccr_pkg::TRIM_W-1:0] trim,
  output logic done,
  output logic donePulse
);
  import ccr_pkg::*;
  // Sized from the parameter so a longer settle unit cannot wrap the counter
  localparam int CNT_W = $clog2((1 << STL_W) * SETTLE_UNIT + 1);

  ccr_tune_state_t state_ff, nxt_state;
  logic [TRIM_W-1:0] trim_ff, nxt_trim, bit_ff, nxt_bit;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done, pulse_ff, nxt_pulse;
  logic [CNT_W-1:0] settleLoad;

  assign settleLoad = CNT_W'((int'(cfg.settle) + 1) * SETTLE_UNIT - 1);
  assign trim = trim_ff;
  assign done = done_ff;
  assign donePulse = pulse_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_trim = trim_ff;
    nxt_bit = bit_ff;
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    nxt_pulse = 1'b0;
    if (pllReset) begin
      // Abort any run; trim kept for software readback
      nxt_state = TUNE_IDLE;
      nxt_done = 1'b0;
    end else begin
      case (state_ff)
        TUNE_IDLE: begin
          if (cfg.enable) begin
            nxt_bit = {1'b1, {(TRIM_W-1){1'b0}}};
            nxt_trim = {1'b1, {(TRIM_W-1){1'b0}}};
            nxt_cnt = settleLoad;
            nxt_state = TUNE_SETTLE;
          end else begin
            nxt_done = 1'b1;
            nxt_pulse = 1'b1;
            nxt_state = TUNE_DONE;
          end
        end
        TUNE_SETTLE: begin
          if (cnt_ff == '0) begin
            nxt_state = TUNE_STEP;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        TUNE_STEP: begin
          // Successive approximation: drop the bit if the VCO runs fast
          if (vcoFastIn) begin
            nxt_trim = trim_ff & ~bit_ff;
          end
          if (bit_ff[0]) begin
            nxt_done = 1'b1;
            nxt_pulse = 1'b1;
            nxt_state = TUNE_DONE;
          end else begin
            nxt_bit = bit_ff >> 1;
            nxt_trim = (vcoFastIn ? (trim_ff & ~bit_ff) : trim_ff) | (bit_ff >> 1);
            nxt_cnt = settleLoad;
            nxt_state = TUNE_SETTLE;
          end
        end
        TUNE_DONE: begin
          if (swTrimWe) begin
            nxt_trim = swTrim;
          end
        end
        default: begin
          nxt_state = TUNE_IDLE;
        end
      endcase
    end
    // Writes during a run would corrupt the search, so they are dropped
    if (swTrimWe && (state_ff == TUNE_IDLE)) begin
      nxt_trim = swTrim;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= TUNE_IDLE;
      trim_ff <= '0;
      bit_ff <= '0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      trim_ff <= nxt_trim;
      bit_ff <= nxt_bit;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      pulse_ff <= nxt_pulse;
    end
  end
endmodule
`default_nettype wire
